// >>> rtl/swc_pkg.sv
/*
  swc_pkg: constants and types for the stop mode wake controller.
  assumes a single 250 MHz clock domain and AXI4-Lite register access.
*/
package swc_pkg;
  localparam int unsigned NUM_EXT = 6;
  localparam int unsigned NUM_SRC = 7;
  localparam logic [2:0] SRC_WATCH = 3'h6;
  localparam logic [2:0] SRC_NONE = 3'h7;

  localparam logic [7:0] ADDR_STANDBY = 8'h00;
  localparam logic [7:0] ADDR_SRC_CFG = 8'h04;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_OSC_SETTLE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PEND_ACK = 8'h14;

  localparam int unsigned STANDBY_STOP_BIT = 0;
  localparam int unsigned CFG_MASK_LSB = 0;
  localparam int unsigned CFG_MACRO_LSB = 8;
  localparam int unsigned CTRL_IE_BIT = 0;
  localparam int unsigned CTRL_NEST3_BIT = 1;
  localparam int unsigned CTRL_ISR_ACT_BIT = 2;
  localparam int unsigned CTRL_ISR_LVL_LSB = 4;
  localparam int unsigned CTRL_NMI_ACT_BIT = 8;
  localparam int unsigned CTRL_NMI_LVL_LSB = 9;
  localparam int unsigned CTRL_SRC_LVL_LSB = 16;

  localparam logic [7:0] SRC_CFG_RESET = 8'h7F;
  localparam logic [2:0] OSC_SETTLE_RESET = 3'h4;
  localparam int unsigned SETTLE_BASE_SHIFT = 4;
  localparam int unsigned SETTLE_CNT_W = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_STOP,
    SWC_SETTLE
  } swc_state_t;
endpackage

// >>> rtl/swc_sync.sv
/*
  swc_sync: three-stage synchroniser with agreement filter for pins.
  assumes inputs are asynchronous to aclk.
*/
`timescale 1ns/1ps
module swc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } swc_sync_st_t;
  swc_sync_st_t q, d;

  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a change counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule

// >>> rtl/swc_wake_ctrl.sv
/*
  swc_wake_ctrl: stop mode wake decision, settle timer and register file.
  assumes the cpu core mirrors its interrupt enable, in-service levels and
  source priorities into the control register, and clears pending flags.
*/
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Operation
// R1 - Stop ends only on an nmi pin edge, an external pin, the watch timer interrupt or reset.
// R2 - An nmi wake is acknowledged if no nmi routine or only a lower one runs.
// R3 - An nmi wake during its own or a higher nmi routine resumes and stays pending.
// R4 - A pending wake request is acknowledged once its conditions become true.
// R5 - A maskable wake with mask 0, macro off and enable 1 over a lower routine is acknowledged.
// R6 - With nesting select 0 a level 3 routine does not defer a maskable wake.
// R7 - A maskable wake over an equal or higher routine resumes and stays pending.
// R8 - A maskable source with its mask bit set never releases stop.
// R9 - A maskable source with macro service enabled never releases stop.
// R10 - A maskable wake with global enable 0 resumes without service.
// R11 - After a wake edge the block waits the programmed settle time before release.
// R12 - Software enters stop by writing 1 to the stop request bit.
// R13 - Priorities are compared using values sampled as stop ends.
module swc_wake_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic nmi_pin,
  input wire logic [5:0] external_int_pins,
  input wire logic watch_timer_irq,
  output logic stop_active,
  output logic wake_ack,
  output logic [2:0] wake_src,
  output logic wake_is_nmi,
  output logic wake_resume,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    swc_pkg::swc_state_t st;
    logic stop_req;
    logic [6:0] mask;
    logic [6:0] macro;
    logic [31:0] ctrl;
    logic [2:0] settle;
    logic [swc_pkg::SETTLE_CNT_W-1:0] cnt;
    logic nmi_prev;
    logic [6:0] src_prev;
    logic [2:0] src;
    logic is_nmi;
    logic nmi_pend;
    logic [6:0] pend;
    logic ack;
    logic resume;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swc_st_t;
  swc_st_t q, d;

  logic [7:0] pins_s;

  swc_sync #(.W(8)) i_swc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin({watch_timer_irq, nmi_pin, external_int_pins}),
    .level(pins_s)
  );

  // maskable acknowledge test against the in-service priority
  function automatic logic mask_ok(input logic [31:0] c, input logic [1:0] lvl);
    logic act;
    logic [1:0] cur;
    act = c[swc_pkg::CTRL_ISR_ACT_BIT];
    cur = c[swc_pkg::CTRL_ISR_LVL_LSB +: 2];
    mask_ok = c[swc_pkg::CTRL_IE_BIT] && // [R5] [R10]
      (!act || lvl < cur || // [R5] [R7]
       (cur == 2'h3 && !c[swc_pkg::CTRL_NEST3_BIT])); // [R6]
  endfunction

  // nmi acknowledge test: lower level number means higher priority
  function automatic logic nmi_ok(input logic [31:0] c);
    nmi_ok = !c[swc_pkg::CTRL_NMI_ACT_BIT] || // [R2]
      (c[swc_pkg::CTRL_NMI_LVL_LSB +: 2] != 2'h0); // [R2] [R3]
  endfunction

  function automatic logic [1:0] src_lvl(input logic [31:0] c, input logic [2:0] s);
    src_lvl = (s == swc_pkg::SRC_WATCH) ? c[swc_pkg::CTRL_SRC_LVL_LSB + 2 +: 2]
                                        : c[swc_pkg::CTRL_SRC_LVL_LSB +: 2];
  endfunction

  logic [6:0] src_now;
  logic [6:0] src_edge;
  logic [6:0] src_valid;
  logic nmi_edge;
  logic aw_hs, w_hs, ar_hs;
  logic [31:0] wr_data;
  logic [7:0] wr_addr;

  assign src_now = {pins_s[7], pins_s[5:0]};
  assign src_edge = src_now & ~q.src_prev;
  assign src_valid = src_edge & ~q.mask & ~q.macro; // [R8] [R9]
  assign nmi_edge = pins_s[6] & ~q.nmi_prev;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign wr_addr = q.aw_got ? q.awaddr : s_axi_awaddr;
  assign wr_data = q.w_got ? q.wdata : s_axi_wdata;

  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.resume = 1'b0;
    d.nmi_prev = pins_s[6];
    d.src_prev = src_now;
    // pending acks retry while running, at most one every other cycle so wake_ack stays a pulse
    if (q.st == swc_pkg::SWC_RUN && !q.ack) begin
      if (q.nmi_pend && nmi_ok(q.ctrl)) begin
        d.nmi_pend = 1'b0; // [R4]
        d.ack = 1'b1;
        d.is_nmi = 1'b1;
        d.src = swc_pkg::SRC_NONE;
      end else begin
        for (int i = swc_pkg::NUM_SRC - 1; i >= 0; i--) begin
          if (q.pend[i] && mask_ok(q.ctrl, src_lvl(q.ctrl, 3'(i)))) begin
            d.pend = q.pend & ~(7'h01 << i); // [R4]
            d.ack = 1'b1;
            d.is_nmi = 1'b0;
            d.src = 3'(i);
          end
        end
      end
    end
    case (q.st)
      swc_pkg::SWC_RUN: begin
        if (q.stop_req) begin
          d.st = swc_pkg::SWC_STOP; // [R12]
          d.stop_req = 1'b0;
        end
      end
      swc_pkg::SWC_STOP: begin
        // only these sources restart; reset is handled by aresetn
        if (nmi_edge) begin // [R1]
          d.st = swc_pkg::SWC_SETTLE;
          d.is_nmi = 1'b1;
          d.src = swc_pkg::SRC_NONE;
          d.cnt = '0;
        end else if (|src_valid) begin // [R1]
          d.st = swc_pkg::SWC_SETTLE;
          d.is_nmi = 1'b0;
          for (int i = swc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (src_valid[i]) begin
              d.src = 3'(i);
            end
          end
          d.cnt = '0;
        end
      end
      swc_pkg::SWC_SETTLE: begin
        d.cnt = q.cnt + 1'b1;
        // settle length 2^(base+sel) cycles stands in for the oscillator wait
        if (q.cnt == swc_pkg::SETTLE_CNT_W'(
            (1 << (swc_pkg::SETTLE_BASE_SHIFT + q.settle)) - 1)) begin
          d.st = swc_pkg::SWC_RUN; // [R11]
          // priorities taken from the control word as stop ends
          if (q.is_nmi) begin
            d.ack = nmi_ok(q.ctrl); // [R13] [R2]
            d.nmi_pend = !nmi_ok(q.ctrl); // [R3]
          end else begin
            d.ack = mask_ok(q.ctrl, src_lvl(q.ctrl, q.src)); // [R13] [R5]
            if (!mask_ok(q.ctrl, src_lvl(q.ctrl, q.src))) begin
              d.pend = q.pend | (7'h01 << q.src); // [R7] [R10]
            end
          end
          d.resume = !d.ack; // [R3] [R7] [R10]
        end
      end
      default: d.st = swc_pkg::SWC_RUN;
    endcase
    // register bus write side
    if (aw_hs) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if ((q.aw_got || aw_hs) && (q.w_got || w_hs)) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = swc_pkg::RESP_OKAY;
      if (wr_addr == swc_pkg::ADDR_STANDBY) begin
        if (wr_data[swc_pkg::STANDBY_STOP_BIT]) begin
          d.stop_req = 1'b1; // [R12]
        end
      end else if (wr_addr == swc_pkg::ADDR_SRC_CFG) begin
        d.mask = wr_data[swc_pkg::CFG_MASK_LSB +: 7];
        d.macro = wr_data[swc_pkg::CFG_MACRO_LSB +: 7];
      end else if (wr_addr == swc_pkg::ADDR_INT_CTRL) begin
        d.ctrl = wr_data;
      end else if (wr_addr == swc_pkg::ADDR_OSC_SETTLE) begin
        d.settle = wr_data[2:0];
      end else if (wr_addr == swc_pkg::ADDR_PEND_ACK) begin
        // cpu clears pending flags by writing ones; a new set wins
        d.pend = d.pend & ~(wr_data[6:0] & q.pend);
        d.nmi_pend = d.nmi_pend & ~(wr_data[7] & q.nmi_pend);
      end else begin
        d.bresp = swc_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // register bus read side
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp = swc_pkg::RESP_OKAY;
      d.rdata = '0;
      if (s_axi_araddr == swc_pkg::ADDR_STANDBY) begin
        d.rdata[swc_pkg::STANDBY_STOP_BIT] = q.stop_req || q.st != swc_pkg::SWC_RUN;
      end else if (s_axi_araddr == swc_pkg::ADDR_SRC_CFG) begin
        d.rdata[swc_pkg::CFG_MASK_LSB +: 7] = q.mask;
        d.rdata[swc_pkg::CFG_MACRO_LSB +: 7] = q.macro;
      end else if (s_axi_araddr == swc_pkg::ADDR_INT_CTRL) begin
        d.rdata = q.ctrl;
      end else if (s_axi_araddr == swc_pkg::ADDR_OSC_SETTLE) begin
        d.rdata[2:0] = q.settle;
      end else if (s_axi_araddr == swc_pkg::ADDR_STATUS) begin
        d.rdata[1:0] = q.st;
        d.rdata[6:4] = q.src;
        d.rdata[7] = q.is_nmi;
      end else if (s_axi_araddr == swc_pkg::ADDR_PEND_ACK) begin
        d.rdata[7:0] = {q.nmi_pend, q.pend};
      end else begin
        d.rresp = swc_pkg::RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= swc_pkg::SWC_RUN; // [R1]
      q.mask <= swc_pkg::SRC_CFG_RESET[6:0];
      q.settle <= swc_pkg::OSC_SETTLE_RESET;
      q.src <= swc_pkg::SRC_NONE;
    end else if (ce) begin
      q <= d;
    end
  end

  assign stop_active = q.st != swc_pkg::SWC_RUN;
  assign wake_ack = q.ack;
  assign wake_src = q.src;
  assign wake_is_nmi = q.is_nmi;
  assign wake_resume = q.resume;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule

// >>> verification/swc_core_model.sv
/*
  swc_core_model: wake source side, raises one chosen pin for 15 cycles.
  assumes fire is a one-cycle request; pins are idle low outside pulses.
*/
`timescale 1ns/1ps
module swc_core_model (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [2:0] src,
  output logic nmi_pin,
  output logic [5:0] external_int_pins,
  output logic watch_timer_irq
);
  logic [3:0] hold_q = 4'h0;
  logic [2:0] src_q = 3'h0;
  logic on;
  // long pulse so the synchroniser agreement filter always sees it
  always_ff @(posedge aclk) begin
    if (fire) begin
      hold_q <= 4'hF;
      src_q <= src;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  assign on = hold_q != 4'h0;
  assign nmi_pin = on && src_q == 3'h7;
  assign watch_timer_irq = on && src_q == 3'h6;
  assign external_int_pins = (on && src_q < 3'h6) ? 6'h01 << src_q : 6'h00;
endmodule

// >>> verification/swc_wake_ctrl_assertions.sv
/*
  swc_wake_ctrl_chk: concurrent checks on the wake controller ports.
  assumes one clock domain and ports as declared by swc_wake_ctrl.
*/
`timescale 1ns/1ps
module swc_wake_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stop_active,
  input wire logic wake_ack,
  input wire logic [2:0] wake_src,
  input wire logic wake_is_nmi,
  input wire logic wake_resume,
  input wire logic s_axi_bvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_release;
    wake_ack || wake_resume;
  endsequence
  // sync plus shortest settle keeps stop up far longer than eight cycles
  sequence s_held;
    stop_active [*8];
  endsequence
  AST_EXIT_BY_WAKE: assert property ($fell(stop_active) |-> ##[0:1] s_release)
    else $error("stop left without a wake pulse");
  AST_SETTLE_MIN: assert property ($rose(stop_active) |-> s_held)
    else $error("stop released too early");
  AST_ENTRY_BY_WRITE: assert property ($rose(stop_active) |->
    $past(s_axi_bvalid, 1) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("stop entered without a register write");
  AST_ACK_PULSE: assert property (wake_ack |=> !wake_ack)
    else $error("ack longer than one cycle");
  AST_RESUME_PULSE: assert property (wake_resume |=> !wake_resume)
    else $error("resume longer than one cycle");
  AST_ONE_OUTCOME: assert property (!(wake_ack && wake_resume))
    else $error("ack and resume together");
  AST_RESUME_AT_EXIT: assert property (wake_resume |->
    !stop_active && ($past(stop_active, 1) || $past(stop_active, 2)))
    else $error("resume outside a stop exit");
  AST_ACK_IN_RUN: assert property (wake_ack |-> !stop_active)
    else $error("ack while stopped");
  AST_NMI_SRC: assert property (wake_is_nmi |-> wake_src == swc_pkg::SRC_NONE)
    else $error("nmi wake with maskable source index");
endmodule
bind swc_wake_ctrl swc_wake_ctrl_chk i_swc_wake_ctrl_chk (
  .aclk(aclk), .aresetn(aresetn), .stop_active(stop_active), .wake_ack(wake_ack),
  .wake_src(wake_src), .wake_is_nmi(wake_is_nmi), .wake_resume(wake_resume),
  .s_axi_bvalid(s_axi_bvalid));

// >>> verification/test_stop_mode_wake_control.sv
/*
  test_stop_mode_wake_control: table of wake cases, then reset, pending and bus cases.
  assumes the controller and core model; ce is held high throughout.
*/
`timescale 1ns/1ps
module test_stop_mode_wake_control;
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] exp;
    logic [31:0] cfg;
    logic [31:0] ctrl;
  } swc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, nmi_pin, watch_timer_irq;
  logic [2:0] fsrc = 3'h0, wake_src;
  logic [5:0] external_int_pins;
  logic stop_active, wake_ack, wake_is_nmi, wake_resume;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rr, br;
  int miscompares = 0, samples_checked = 0;
  // outcome code: 0 stays stopped, 1 acknowledged, 2 resumed
  swc_row_t rows [11] = '{
    '{3'h0, 2'h1, 32'h7E, 32'h1},
    '{3'h3, 2'h1, 32'h77, 32'h10035},
    '{3'h2, 2'h2, 32'h7B, 32'h10015},
    '{3'h6, 2'h1, 32'h3F, 32'hC0035},
    '{3'h6, 2'h2, 32'h3F, 32'hC0037},
    '{3'h1, 2'h2, 32'h7D, 32'h0},
    '{3'h7, 2'h1, 32'h7F, 32'h0},
    '{3'h7, 2'h2, 32'h7F, 32'h100},
    '{3'h7, 2'h1, 32'h7F, 32'h300},
    '{3'h4, 2'h0, 32'h7F, 32'h1},
    '{3'h5, 2'h0, 32'h205F, 32'h1}
  };
  swc_wake_ctrl i_swc_wake_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .nmi_pin(nmi_pin),
    .external_int_pins(external_int_pins), .watch_timer_irq(watch_timer_irq),
    .stop_active(stop_active), .wake_ack(wake_ack), .wake_src(wake_src),
    .wake_is_nmi(wake_is_nmi), .wake_resume(wake_resume), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  swc_core_model i_swc_core_model (.aclk(aclk), .fire(fire), .src(fsrc), .nmi_pin(nmi_pin),
    .external_int_pins(external_int_pins), .watch_timer_irq(watch_timer_irq));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task close_out;
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bready and rready stay high, so only valids toggle between transfers
  task axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
  endtask
  task axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask
  task reset_dut;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task wait_out(input int lim, output logic [1:0] got, output int n);
    got = 2'h0;
    n = 0;
    while (got == 2'h0 && n < lim) begin
      @(posedge aclk);
      n++;
      if (wake_ack) got = 2'h1;
      else if (wake_resume) got = 2'h2;
    end
  endtask
  task run_row(input swc_row_t r, input int sel);
    logic [1:0] got;
    int n;
    int lo;
    lo = 1 << (swc_pkg::SETTLE_BASE_SHIFT + sel);
    reset_dut;
    axw(swc_pkg::ADDR_SRC_CFG, r.cfg);
    axw(swc_pkg::ADDR_INT_CTRL, r.ctrl);
    axw(swc_pkg::ADDR_OSC_SETTLE, 32'(sel));
    axw(swc_pkg::ADDR_STANDBY, 32'h1);
    repeat (3) @(posedge aclk);
    chk("stop_active", 32'(stop_active), 32'h1);
    fire <= 1'b1;
    fsrc <= r.src;
    @(posedge aclk);
    fire <= 1'b0;
    wait_out(200, got, n);
    chk("outcome", 32'(got), 32'(r.exp));
    if (r.exp == 2'h1) chk("src", 32'(wake_src), 32'(r.src));
    if (r.exp == 2'h1) chk("is_nmi", 32'(wake_is_nmi), 32'(r.src == 3'h7));
    if (r.exp != 2'h0) chk("settle", 32'(n >= lo && n <= lo + 12), 32'h1);
    else chk("held", 32'(stop_active), 32'h1);
  endtask
  initial begin
    #50000;
    miscompares++;
    close_out;
  end
  initial begin
    logic [1:0] got;
    int n;
    for (int i = 0; i < 11; i++) run_row(rows[i], i % 3);
    reset_dut;
    axr(swc_pkg::ADDR_SRC_CFG);
    chk("cfg_reset", rd, 32'(swc_pkg::SRC_CFG_RESET));
    axr(swc_pkg::ADDR_OSC_SETTLE);
    chk("settle_reset", rd, 32'(swc_pkg::OSC_SETTLE_RESET));
    axr(8'h3C);
    chk("unmapped_resp", 32'(rr), 32'(swc_pkg::RESP_SLVERR));
    chk("unmapped_data", rd, 32'h0);
    run_row(rows[2], 0);
    axr(swc_pkg::ADDR_PEND_ACK);
    chk("pending", rd, 32'h04);
    axw(swc_pkg::ADDR_INT_CTRL, 32'h10035);
    wait_out(40, got, n);
    chk("pending_ack", 32'(got), 32'h1);
    chk("pending_src", 32'(wake_src), 32'h2);
    axr(swc_pkg::ADDR_PEND_ACK);
    chk("pending_clear", rd, 32'h0);
    axw(swc_pkg::ADDR_INT_CTRL, 32'h0);
    chk("wr_okay", 32'(br), 32'(swc_pkg::RESP_OKAY));
    axw(8'h3C, 32'h1);
    chk("wr_unmapped", 32'(br), 32'(swc_pkg::RESP_SLVERR));
    run_row(rows[7], 1);
    axr(swc_pkg::ADDR_PEND_ACK);
    chk("nmi_pending", rd, 32'h80);
    axw(swc_pkg::ADDR_INT_CTRL, 32'h0);
    wait_out(40, got, n);
    chk("nmi_pending_ack", 32'(got), 32'h1);
    chk("nmi_pending_is_nmi", 32'(wake_is_nmi), 32'h1);
    axr(swc_pkg::ADDR_STATUS);
    chk("status", rd, 32'hF0);
    axr(swc_pkg::ADDR_PEND_ACK);
    chk("nmi_pending_clear", rd, 32'h0);
    close_out;
  end
endmodule
